// file: rtl/ssc_pkg.sv
// Package for the bus sequence control register block: map, fields, states
package ssc_pkg;
    localparam int ssc_data_w = 8;
    localparam int ssc_off_w = 8;
    localparam int ssc_prefix_w = 24;
    localparam logic [7:0] ssc_off_bus_sequence_control = 8'h00;
    localparam logic [7:0] ssc_reset_value = 8'h00;
    localparam int ssc_bit_outgoing_reselect_mode = 7;
    localparam int ssc_bit_start_outgoing_selection = 6;
    localparam int ssc_bit_accept_incoming_selection = 5;
    localparam int ssc_bit_accept_incoming_reselection = 4;
    localparam int ssc_bit_auto_attention_on_select = 3;
    localparam int ssc_bit_auto_attention_on_reselect = 2;
    localparam int ssc_bit_auto_attention_on_parity = 1;
    localparam int ssc_bit_bus_reset_drive = 0;
    // Bus reset keeps only the reset-drive bit
    localparam logic [7:0] ssc_bus_reset_keep = 8'h01;
    localparam int ssc_id_w = 4;

    typedef struct packed {
        logic outgoing_reselect_mode;
        logic start_outgoing_selection;
        logic accept_incoming_selection;
        logic accept_incoming_reselection;
        logic auto_attention_on_select;
        logic auto_attention_on_reselect;
        logic auto_attention_on_parity;
        logic bus_reset_drive;
    } ssc_ctrl_type;

    // Register access port, one per master
    typedef struct packed {
        logic wr;
        logic rd;
        logic [31:0] addr;
        logic [7:0] wdata;
    } ssc_req_type;

    // Bus events seen by the bus front end, all one-cycle or level
    typedef struct packed {
        logic bus_reset_seen;
        logic bus_free;
        logic bsy_back;
        logic selected_valid;
        logic reselected_valid;
        logic data_in_phase;
        logic parity_err_lo;
        logic parity_err_hi;
    } ssc_evt_type;

    typedef enum logic [1:0] {
        ssc_idle,
        ssc_selecting,
        ssc_connected
    } ssc_state_type;
endpackage

// file: rtl/ssc_sequence_control.sv
// Bus sequence control register with its outgoing and incoming selection logic
// Operation
// - Bit 7 picks Selection (clear) or Reselection (set) for the outgoing start.
// - Bit 6 starts outgoing sequence with own ID toward the peer ID.
// - Selection-in-progress is one while in select phase awaiting BSY.
// - Start-selection bit clears only by register write, bus reset or hard reset.
// - Bit 5 answers incoming Selection; sets selected-in and target role.
// - Hardware clears selection-in enable only on bus reset; otherwise register writes do.
// - Bit 4 answers incoming Reselection; sets selected-in, clears target role.
// - Reselection-in enable clears only by an explicit zero write or bus reset.
// - Bit 3 asserts ATN during initiator Selection.
// - Bit 2 asserts ATN when reselected with reselection-in enabled.
// - Bit 1 with parity check, as initiator, asserts ATN on input parity error.
// - Auto ATN released by clear-ATN write or Bus Free; zero writes leave it.
// - Bit 0 drives bus reset regardless of role until written zero.
// - Bus reset clears every bit except the reset-drive bit.
// - Register reads back written value; all zero during chip reset.
// - Register decodes at offset zero in host window and device space.
// - Host access matches upper prefix against either base prefix register.
// - Sequencer addresses registers by device-space offset alone.
`timescale 1ns/100ps
`default_nettype none
module ssc_sequence_control
    import ssc_pkg::*;
#(
    parameter int id_w = ssc_id_w
) (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Host memory window
    input wire ssc_pkg::ssc_req_type host_req,
    input wire logic [ssc_prefix_w-1:0] base_prefix_zero,
    input wire logic [ssc_prefix_w-1:0] base_prefix_one,
    output logic [ssc_data_w-1:0] host_rdata,
    output logic host_hit,
    // Sequencer device space
    input wire ssc_pkg::ssc_req_type seq_req,
    output logic [ssc_data_w-1:0] seq_rdata,
    output logic seq_hit,
    // Related control and status bits from neighbouring registers
    input wire logic [id_w-1:0] own_id_field,
    input wire logic [id_w-1:0] peer_id_field,
    input wire logic bus_parity_check_enable,
    input wire logic clear_attention_out,
    input wire logic status_clear,
    // Bus events
    input wire ssc_pkg::ssc_evt_type bus_evt,
    // Outgoing sequence to the bus front end
    output logic sel_drive,
    output logic sel_as_target,
    output logic [id_w-1:0] sel_own_id,
    output logic [id_w-1:0] sel_peer_id,
    // Status
    output logic selection_in_progress,
    output logic selection_done_flag,
    output logic selected_in_flag,
    output logic target_role,
    // Open-drain bus pins
    input wire logic atn_in,
    output logic atn_out,
    output logic atn_oe_n,
    input wire logic bus_reset_in,
    output logic bus_reset_out,
    output logic bus_reset_oe_n
);

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode

    // Host hits only when the upper prefix matches one of the two base registers
    function automatic logic host_match(input logic [31:0] a, input logic [23:0] p0,
                                        input logic [23:0] p1, input logic [7:0] off);
        host_match = ((a[31:ssc_off_w] == p0) || (a[31:ssc_off_w] == p1))
                     && (a[ssc_off_w-1:0] == off);
    endfunction

    wire logic host_sel;
    wire logic seq_sel;
    wire logic host_wr_hit;
    wire logic seq_wr_hit;
    assign host_sel = host_match(host_req.addr, base_prefix_zero, base_prefix_one,
                                 ssc_off_bus_sequence_control);
    assign seq_sel = seq_req.addr[ssc_off_w-1:0] == ssc_off_bus_sequence_control;
    assign host_wr_hit = host_req.wr && host_sel;
    assign seq_wr_hit = seq_req.wr && seq_sel;

    ////////////////////////////////////////////////////////////////////////////////
    // Register

    ssc_ctrl_type ctrl_q;
    ssc_ctrl_type ctrl_d;
    wire logic [7:0] ctrl_bits;
    wire logic [7:0] wr_value;
    assign ctrl_bits = ctrl_q;
    // Sequencer wins a same-cycle collision; it owns the sequence bits
    assign wr_value = seq_wr_hit ? seq_req.wdata : host_req.wdata;

    // Only writes and bus reset change bits 6..4; no selection event clears them
    always_comb begin
        ctrl_d = ctrl_q;
        if (seq_wr_hit || host_wr_hit) begin
            ctrl_d = wr_value;
        end
        if (bus_evt.bus_reset_seen) begin
            ctrl_d = ctrl_d & ssc_bus_reset_keep;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= ssc_reset_value;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outgoing sequence

    ssc_state_type state_q;
    ssc_state_type state_d;
    wire logic out_start;
    wire logic in_sel_ok;
    wire logic in_resel_ok;
    assign out_start = ctrl_q.start_outgoing_selection;
    assign in_sel_ok = ctrl_q.accept_incoming_selection && bus_evt.selected_valid;
    assign in_resel_ok = ctrl_q.accept_incoming_reselection
                         && bus_evt.reselected_valid;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ssc_idle: begin
                if (out_start) begin
                    state_d = ssc_selecting;
                end else if (in_sel_ok || in_resel_ok) begin
                    state_d = ssc_connected;
                end
            end
            ssc_selecting: begin
                if (bus_evt.bus_reset_seen || !out_start) begin
                    // Sequencer abandons a stalled selection by clearing the start bit
                    state_d = ssc_idle;
                end else if (bus_evt.bsy_back) begin
                    state_d = ssc_connected;
                end
            end
            ssc_connected: begin
                if (bus_evt.bus_free || bus_evt.bus_reset_seen) begin
                    state_d = ssc_idle;
                end
            end
            default: begin
                state_d = ssc_idle;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= ssc_idle;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status flags

    logic done_q;
    logic selin_q;
    logic target_q;
    wire logic done_set;
    wire logic initiator;
    assign done_set = (state_q == ssc_selecting) && bus_evt.bsy_back && out_start
                      && !bus_evt.bus_reset_seen;
    // Role after an outgoing win follows the mode bit
    assign initiator = !target_q;

    // Set beats the clear so an event landing on a clear is kept
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            done_q <= 1'b0;
            selin_q <= 1'b0;
            target_q <= 1'b0;
        end else begin
            done_q <= done_set || (done_q && !status_clear);
            selin_q <= (state_q == ssc_idle && !out_start && (in_sel_ok || in_resel_ok))
                       || (selin_q && !status_clear);
            if (done_set) begin
                target_q <= ctrl_q.outgoing_reselect_mode;
            end else if (state_q == ssc_idle && !out_start && in_sel_ok) begin
                target_q <= 1'b1;
            end else if (state_q == ssc_idle && !out_start && in_resel_ok) begin
                target_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Automatic attention

    logic atn_q;
    logic atn_oe_n_q;
    wire logic atn_sel_cond;
    wire logic atn_resel_cond;
    wire logic atn_par_cond;
    wire logic atn_set;
    wire logic atn_d;
    assign atn_sel_cond = ctrl_q.auto_attention_on_select && (state_q == ssc_selecting)
                          && !ctrl_q.outgoing_reselect_mode;
    assign atn_resel_cond = ctrl_q.auto_attention_on_reselect && in_resel_ok
                            && (state_q == ssc_idle) && !out_start;
    assign atn_par_cond = ctrl_q.auto_attention_on_parity && bus_parity_check_enable
                          && initiator && (state_q == ssc_connected)
                          && bus_evt.data_in_phase
                          && (bus_evt.parity_err_lo || bus_evt.parity_err_hi);
    assign atn_set = atn_sel_cond || atn_resel_cond || atn_par_cond;
    // Disabling an enable does not drop ATN once raised
    assign atn_d = atn_set || (atn_q && !clear_attention_out && !bus_evt.bus_free);

    // Enable kept in its own flop so the pin comes straight from a register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            atn_q <= 1'b0;
            atn_oe_n_q <= 1'b1;
        end else begin
            atn_q <= atn_d;
            atn_oe_n_q <= !atn_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registered outputs

    logic [7:0] host_rdata_q;
    logic [7:0] seq_rdata_q;
    logic host_hit_q;
    logic seq_hit_q;
    logic sel_drive_q;
    logic sel_as_target_q;
    logic [id_w-1:0] own_q;
    logic [id_w-1:0] peer_q;
    logic rst_drive_q;
    logic rst_oe_n_q;
    logic sigo_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            host_rdata_q <= ssc_reset_value;
            seq_rdata_q <= ssc_reset_value;
            host_hit_q <= 1'b0;
            seq_hit_q <= 1'b0;
        end else begin
            host_hit_q <= (host_req.rd || host_req.wr) && host_sel;
            seq_hit_q <= (seq_req.rd || seq_req.wr) && seq_sel;
            host_rdata_q <= (host_req.rd && host_sel) ? ctrl_bits : 8'h00;
            seq_rdata_q <= (seq_req.rd && seq_sel) ? ctrl_bits : 8'h00;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sel_drive_q <= 1'b0;
            sel_as_target_q <= 1'b0;
            own_q <= '0;
            peer_q <= '0;
            rst_drive_q <= 1'b0;
            rst_oe_n_q <= 1'b1;
            sigo_q <= 1'b0;
        end else begin
            sel_drive_q <= state_d == ssc_selecting;
            sel_as_target_q <= ctrl_d.outgoing_reselect_mode;
            own_q <= own_id_field;
            peer_q <= peer_id_field;
            rst_drive_q <= ctrl_d.bus_reset_drive;
            rst_oe_n_q <= !ctrl_d.bus_reset_drive;
            sigo_q <= state_d == ssc_selecting;
        end
    end

    assign host_rdata = host_rdata_q;
    assign seq_rdata = seq_rdata_q;
    assign host_hit = host_hit_q;
    assign seq_hit = seq_hit_q;
    assign sel_drive = sel_drive_q;
    assign sel_as_target = sel_as_target_q;
    assign sel_own_id = own_q;
    assign sel_peer_id = peer_q;
    assign selection_in_progress = sigo_q;
    assign selection_done_flag = done_q;
    assign selected_in_flag = selin_q;
    assign target_role = target_q;
    assign atn_out = atn_q;
    // Open drain: enable low while pulling the line
    assign atn_oe_n = atn_oe_n_q;
    assign bus_reset_out = rst_drive_q;
    assign bus_reset_oe_n = rst_oe_n_q;

    // Line levels are read by the front end, not here
    wire logic unused_pins;
    assign unused_pins = atn_in ^ bus_reset_in;

endmodule // ssc_sequence_control
`default_nettype wire

// file: dv/ssc_sequence_control_props.sv
// Checker for the bus sequence control register ports
`timescale 1ns/100ps
`default_nettype none
module ssc_sequence_control_props
    import ssc_pkg::*;
(
    // Clock, reset and register ports
    input wire logic clock,
    input wire logic nrst,
    input wire ssc_pkg::ssc_req_type host_req,
    input wire ssc_pkg::ssc_req_type seq_req,
    input wire logic [ssc_prefix_w-1:0] base_prefix_zero,
    input wire logic [ssc_prefix_w-1:0] base_prefix_one,
    input wire logic host_hit,
    input wire logic seq_hit,
    input wire logic [ssc_data_w-1:0] seq_rdata,
    // Bus side
    input wire logic clear_attention_out,
    input wire ssc_pkg::ssc_evt_type bus_evt,
    input wire logic sel_drive,
    input wire logic selection_done_flag,
    input wire logic atn_out,
    input wire logic bus_reset_out,
    input wire logic bus_reset_oe_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    wire pre_z = host_req.addr[31:8] == base_prefix_zero;
    wire pre_o = host_req.addr[31:8] == base_prefix_one;
    wire host_acc = host_req.wr | host_req.rd;
    wire seq_at0 = seq_req.addr[7:0] == 8'h00;
    // Collisions and bus reset are left out, their outcome is another rule
    wire quiet = !host_req.wr & !bus_evt.bus_reset_seen;
    wire seq_wr0 = seq_req.wr & seq_at0 & quiet;
    wire seq_rd0 = seq_req.rd & !seq_req.wr & seq_at0 & !host_req.wr;
    wire host_at0 = host_req.addr[7:0] == 8'h00;
    wire no_wr = !seq_req.wr & !host_req.wr;
    wire rst_on = bus_reset_out & !bus_reset_oe_n;
    wire sel_ans = sel_drive & bus_evt.bsy_back & quiet & !seq_req.wr;
    wire atn_keep = !clear_attention_out & !bus_evt.bus_free & !bus_evt.bus_reset_seen;
    wire atn_src = sel_drive | bus_evt.reselected_valid | bus_evt.parity_err_lo
        | bus_evt.parity_err_hi;
    // Accesses are one-cycle pulses with an idle edge between them
    sequence wr_gap_rd;
        seq_wr0 ##1 no_wr & quiet ##1 seq_rd0 & quiet;
    endsequence
    sequence rst_gap_rd;
        bus_evt.bus_reset_seen ##1 no_wr ##1 seq_rd0;
    endsequence
    AST_SEQ_DECODE: assert property ((seq_req.wr | seq_req.rd) & seq_at0 |=> seq_hit)
        else $error("no seq hit");
    AST_HOST_DECODE: assert property (host_acc & (pre_z | pre_o) & host_at0 |=> host_hit)
        else $error("no host hit");
    AST_HOST_MISS: assert property (host_acc & !pre_z & !pre_o |=> !host_hit)
        else $error("host hit off prefix");
    AST_READBACK: assert property (wr_gap_rd |=> seq_rdata == $past(seq_req.wdata, 3))
        else $error("readback differs");
    AST_BUS_RESET_CLEAR: assert property (rst_gap_rd |=> seq_rdata[7:1] == 7'h00)
        else $error("bus reset left bits");
    AST_RESET_DRIVE: assert property (seq_wr0 & seq_req.wdata[0] |-> ##[1:2] rst_on)
        else $error("bus reset not driven");
    // A write in the cycle before may have just dropped the start bit
    AST_SEL_DONE: assert property (sel_ans & !$past(no_wr == 1'b0) |=> selection_done_flag & !sel_drive)
        else $error("selection not done");
    AST_ATN_HOLD: assert property (atn_out & atn_keep |=> atn_out)
        else $error("atn dropped");
    AST_ATN_CAUSE: assert property ($rose(atn_out) |-> $past(atn_src))
        else $error("atn without cause");
    cover property ($rose(selection_done_flag));
    cover property ($rose(atn_out));
    cover property ($rose(bus_reset_out));
endmodule // ssc_sequence_control_props
bind ssc_sequence_control ssc_sequence_control_props ssc_sequence_control_props_inst (.clock,
    .nrst, .host_req, .seq_req, .base_prefix_zero, .base_prefix_one, .host_hit, .seq_hit,
    .seq_rdata, .clear_attention_out, .bus_evt, .sel_drive, .selection_done_flag, .atn_out,
    .bus_reset_out, .bus_reset_oe_n);
`default_nettype wire

// file: dv/ssc_bus_peer.sv
// Far-side bus party model: answers BSY after a chosen delay
`timescale 1ns/100ps
`default_nettype none
module ssc_bus_peer
    import ssc_pkg::*;
(
    // Clock, reset and device side
    input wire logic clock,
    input wire logic nrst,
    input wire logic sel_drive,
    // Scenario controls; zero delay means nobody answers
    input wire logic [3:0] bsy_delay,
    input wire ssc_pkg::ssc_evt_type evt_cmd,
    output var ssc_pkg::ssc_evt_type bus_evt
);
    logic [3:0] wait_q;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) wait_q <= 4'h0;
        else wait_q <= sel_drive ? wait_q + 4'h1 : 4'h0;
    end
    always_comb begin
        bus_evt = evt_cmd;
        bus_evt.bsy_back = evt_cmd.bsy_back
            | (sel_drive & bsy_delay != 4'h0 & wait_q == bsy_delay);
    end
endmodule // ssc_bus_peer
`default_nettype wire

// file: dv/ssc_sequence_control_test.sv
// Self-checking bench for the bus sequence control register
`timescale 1ns/100ps
`default_nettype none
module ssc_sequence_control_test;
    import ssc_pkg::*;
    ////////////////////////////////////////
    localparam logic [23:0] pre0 = 24'h123456;
    localparam logic [23:0] pre1 = 24'h00abcd;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic par_en = 1'b0;
    logic clr_atn = 1'b0;
    logic st_clr = 1'b0;
    logic [3:0] bsy_delay = 4'h0;
    ssc_req_type host_req = '0;
    ssc_req_type seq_req = '0;
    ssc_evt_type evt_cmd = '0;
    ssc_evt_type bus_evt;
    logic [7:0] host_rdata, seq_rdata, rd;
    logic [3:0] s_own, s_peer;
    logic host_hit, seq_hit, hit, sel_drive, as_tgt, sip, done, sel_in, tgt;
    logic atn_out, atn_oe_n, brst_out, brst_oe_n;
    int num_errors = 0;
    int check_count = 0;
    always #2.5 clock = ~clock;
    // Open-drain lines with pull-ups read back the output enables
    ssc_sequence_control ssc_sequence_control_inst (.clock, .nrst, .host_req,
        .base_prefix_zero(pre0), .base_prefix_one(pre1), .host_rdata, .host_hit, .seq_req,
        .seq_rdata, .seq_hit, .own_id_field(4'h3), .peer_id_field(4'h5),
        .bus_parity_check_enable(par_en), .clear_attention_out(clr_atn), .status_clear(st_clr),
        .bus_evt, .sel_drive, .sel_as_target(as_tgt), .sel_own_id(s_own), .sel_peer_id(s_peer),
        .selection_in_progress(sip), .selection_done_flag(done), .selected_in_flag(sel_in),
        .target_role(tgt), .atn_in(atn_oe_n), .atn_out, .atn_oe_n, .bus_reset_in(brst_oe_n),
        .bus_reset_out(brst_out), .bus_reset_oe_n(brst_oe_n));
    ssc_bus_peer ssc_bus_peer_inst (.clock, .nrst, .sel_drive, .bsy_delay, .evt_cmd, .bus_evt);
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic host, input logic w, input logic [31:0] a, input logic [7:0] d);
        ssc_req_type r;
        r = '{wr: w, rd: !w, addr: a, wdata: d};
        if (host) host_req = r;
        else seq_req = r;
        tick(1);
        rd = host ? host_rdata : seq_rdata;
        hit = host ? host_hit : seq_hit;
        host_req = '0;
        seq_req = '0;
        // Idle edge so a following access never reassigns the request in one step
        tick(1);
    endtask
    task automatic sw(input logic [7:0] d);
        acc(1'b0, 1'b1, 32'h0, d);
    endtask
    task automatic sr(input logic [7:0] exp);
        acc(1'b0, 1'b0, 32'h0, 8'h00);
        check(rd, exp);
    endtask
    task automatic pulse(input ssc_evt_type e, input logic [1:0] c);
        evt_cmd = e;
        {clr_atn, st_clr} = c;
        tick(1);
        evt_cmd = '0;
        {clr_atn, st_clr} = 2'b00;
        tick(1);
    endtask
    task automatic t_regs();
        check({6'h0, atn_oe_n, brst_oe_n}, 8'h03);
        sr(8'h00);
        acc(1'b1, 1'b1, {pre0, 8'h00}, 8'h30);
        check({7'h0, hit}, 8'h01);
        acc(1'b1, 1'b0, {pre1, 8'h00}, 8'h00);
        check(rd, 8'h30);
        acc(1'b1, 1'b1, {24'h0badcf, 8'h00}, 8'h0f);
        acc(1'b0, 1'b0, 32'h1, 8'h00);
        check({hit, rd[6:0]}, 8'h00);
        sr(8'h30);
        sw(8'h3c);
        sr(8'h3c);
        sw(8'h00);
        $display("test regs done");
    endtask
    task automatic t_out();
        bsy_delay = 4'h3;
        sw(8'h48);
        tick(2);
        check({sip, sel_drive, as_tgt, atn_out, s_own}, 8'hd3);
        check({7'h0, atn_oe_n}, 8'h00);
        check({4'h0, s_peer}, 8'h05);
        for (int i = 0; i < 30 && done !== 1'b1; i++) tick(1);
        check({done, sel_drive, tgt, atn_out, 4'h0}, 8'h90);
        sr(8'h48);
        sw(8'h00);
        check({7'h0, atn_out}, 8'h01);
        pulse(8'h00, 2'b11);
        check({6'h0, atn_out, done}, 8'h00);
        pulse(8'h40, 2'b00);
        bsy_delay = 4'h2;
        sw(8'hc0);
        for (int i = 0; i < 30 && done !== 1'b1; i++) tick(1);
        check({done, tgt, as_tgt, atn_out, 4'h0}, 8'he0);
        sw(8'h00);
        pulse(8'h40, 2'b01);
        bsy_delay = 4'h0;
        sw(8'h40);
        tick(20);
        check({6'h0, sip, done}, 8'h02);
        sr(8'h40);
        sw(8'h00);
        tick(1);
        check({7'h0, sip}, 8'h00);
        $display("test outgoing done");
    endtask
    task automatic t_in();
        sw(8'h20);
        pulse(8'h10, 2'b00);
        check({6'h0, sel_in, tgt}, 8'h03);
        sr(8'h20);
        pulse(8'h40, 2'b01);
        sw(8'h14);
        pulse(8'h08, 2'b00);
        tick(1);
        check({5'h0, sel_in, tgt, atn_out}, 8'h05);
        sr(8'h14);
        pulse(8'h40, 2'b01);
        check({7'h0, atn_out}, 8'h00);
        par_en = 1'b1;
        bsy_delay = 4'h2;
        sw(8'h42);
        for (int i = 0; i < 30 && done !== 1'b1; i++) tick(1);
        sw(8'h02);
        pulse(8'h04, 2'b00);
        check({7'h0, atn_out}, 8'h00);
        pulse(8'h05, 2'b00);
        check({7'h0, atn_out}, 8'h01);
        pulse(8'h00, 2'b11);
        par_en = 1'b0;
        pulse(8'h06, 2'b00);
        check({7'h0, atn_out}, 8'h00);
        pulse(8'h40, 2'b00);
        $display("test incoming done");
    endtask
    task automatic t_rst();
        sw(8'hbf);
        tick(1);
        check({6'h0, brst_out, brst_oe_n}, 8'h02);
        pulse(8'h80, 2'b00);
        sr(8'h01);
        sw(8'h00);
        tick(1);
        check({6'h0, brst_out, brst_oe_n}, 8'h01);
        $display("test bus reset done");
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        tick(6);
        nrst = 1'b1;
        tick(1);
        t_regs();
        t_out();
        t_in();
        t_rst();
        conclude();
    end
    // The run needs little more than a hundred cycles, so this only trips on a hang
    initial begin
        repeat (4000) @(posedge clock);
        num_errors++;
        conclude();
    end
endmodule // ssc_sequence_control_test
`default_nettype wire
